// ===== logic/alsrd_pkg.sv
package alsrd_pkg;
    // bus address: 26h write, 27h read
    localparam logic [6:0] DEV_ADDR = 7'h13;
    localparam logic [7:0] PTR_CMD = 8'h80;
    localparam logic [7:0] PTR_LED = 8'h83;
    localparam logic [7:0] PTR_CFG = 8'h84;
    localparam logic [7:0] PTR_RES_HI = 8'h85;
    localparam logic [7:0] PTR_RES_LO = 8'h86;
    localparam logic [7:0] READ_NONE = 8'h00;
    localparam int CMD_PROX_EN_BIT = 1;
    localparam int CMD_ALS_EN_BIT = 2;
    localparam int CFG_CONT_BIT = 7;
    localparam int CFG_AVG_LSB = 0;
    localparam int CFG_AVG_W = 3;
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [7:0] LED_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    // crossing word: {prox_en, als_en, led, cfg}
    localparam int XFER_W = 18;
    localparam int XFER_PROX_BIT = 17;
    localparam int XFER_ALS_BIT = 16;
    localparam int XFER_LED_LSB = 8;
    localparam int XFER_CFG_LSB = 0;
    localparam int CLK_FREQ_MHZ = 25;
    localparam int FRAME_TIME_US = 100000;
    localparam int CONV_TIME_US = 300;
    localparam int FRAME_CYCLES = FRAME_TIME_US * CLK_FREQ_MHZ;
    localparam int CONV_CYCLES = CONV_TIME_US * CLK_FREQ_MHZ;
    localparam int FRAME_CNT_W = 22;
    localparam int CONV_CNT_W = 13;
endpackage

// ===== logic/alsrd_word_xfer.sv
`timescale 1ns/10ps
// toggle handshake word crossing; a send while busy is resent with newest data
module alsrd_word_xfer #(
    parameter int WIDTH = 16
) (
    input wire logic src_clk_i,
    input wire logic src_rst_i,
    input wire logic send_i,
    input wire logic [WIDTH-1:0] data_i,
    input wire logic dst_clk_i,
    input wire logic dst_rst_i,
    output logic [WIDTH-1:0] data_o,
    output logic valid_o
);
    logic pending;
    logic req_tgl;
    logic [WIDTH-1:0] hold;
    logic ack_m;
    logic ack_s;
    logic req_m;
    logic req_s;
    logic req_d;
    logic ack_tgl;
    wire src_idle = (req_tgl == ack_s);
    wire launch = src_idle && (pending || send_i);

    always_ff @(posedge src_clk_i)
    begin
        if (src_rst_i)
        begin
            pending <= 1'b0;
            req_tgl <= 1'b0;
            hold <= '0;
            ack_m <= 1'b0;
            ack_s <= 1'b0;
        end
        else
        begin
            pending <= (pending || send_i) && !launch;
            if (launch)
            begin
                hold <= data_i;
                req_tgl <= ~req_tgl;
            end
            ack_m <= ack_tgl;
            ack_s <= ack_m;
        end
    end

    always_ff @(posedge dst_clk_i)
    begin
        if (dst_rst_i)
        begin
            req_m <= 1'b0;
            req_s <= 1'b0;
            req_d <= 1'b0;
            ack_tgl <= 1'b0;
            data_o <= '0;
            valid_o <= 1'b0;
        end
        else
        begin
            req_m <= req_tgl;
            req_s <= req_m;
            req_d <= req_s;
            ack_tgl <= req_d;
            valid_o <= (req_s != req_d);
            if (req_s != req_d)
                data_o <= hold;
        end
    end
endmodule

// ===== logic/alsrd_conv.sv
`timescale 1ns/10ps
// ambient conversion sequencer with averaging
module alsrd_conv #(
    parameter int FRAME_CYCLES = alsrd_pkg::FRAME_CYCLES,
    parameter int CONV_CYCLES = alsrd_pkg::CONV_CYCLES
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic enable_i,
    input wire logic cont_i,
    input wire logic [2:0] avg_sel_i,
    input wire logic [15:0] adc_data_i,
    output logic conv_busy_o,
    output logic [15:0] result_o,
    output logic result_valid_o
);
    logic [alsrd_pkg::FRAME_CNT_W-1:0] frame_cnt;
    logic [alsrd_pkg::CONV_CNT_W-1:0] conv_cnt;
    logic [7:0] done_cnt;
    logic [22:0] acc;
    wire [7:0] target = 8'h01 << avg_sel_i;
    wire running = enable_i && (done_cnt != target);
    wire conv_end = running && (conv_cnt == 13'(CONV_CYCLES - 1)); // [RULE_11]
    wire last_conv = conv_end && (8'(done_cnt + 8'h01) == target);
    wire frame_end = frame_cnt == 22'(FRAME_CYCLES - 1); // [RULE_10]
    // standard: publish at frame end only; continuous: after last conversion
    wire publish = enable_i && (cont_i ? last_conv : (frame_end && !running)); // [RULE_13] [RULE_09]
    wire [22:0] next_acc = acc + {7'h00, adc_data_i};
    wire [22:0] avg_src = cont_i ? next_acc : acc;

    assign conv_busy_o = running;

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || !enable_i) // [RULE_01]
        begin
            frame_cnt <= '0;
            conv_cnt <= '0;
            done_cnt <= 8'h00;
            acc <= '0;
        end
        else
        begin
            frame_cnt <= (frame_end || cont_i) ? '0 : frame_cnt + 22'h000001;
            conv_cnt <= (conv_end || !running) ? '0 : conv_cnt + 13'h0001; // [RULE_14]
            if (publish)
            begin
                done_cnt <= 8'h00;
                acc <= '0;
            end
            else if (conv_end)
            begin
                done_cnt <= done_cnt + 8'h01;
                acc <= next_acc; // [RULE_12]
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            result_o <= alsrd_pkg::RESULT_RESET;
            result_valid_o <= 1'b0;
        end
        else
        begin
            result_valid_o <= publish;
            if (publish)
                result_o <= 16'(avg_src >> avg_sel_i); // [RULE_12]
        end
    end

    property p_std_frame_end;
        @(posedge clk_i) disable iff (sys_rst_i)
        (result_valid_o && !$past(cont_i)) |-> $past(frame_end);
    endproperty
    a_std_frame_end: assert property (p_std_frame_end) // [RULE_13]
        else $error("standard result outside frame end");

    property p_cont_no_gap;
        @(posedge clk_i) disable iff (sys_rst_i)
        (enable_i && cont_i && conv_end) ##1 (enable_i && cont_i && $stable(avg_sel_i))
            |-> conv_busy_o && (conv_cnt == '0);
    endproperty
    a_cont_no_gap: assert property (p_cont_no_gap) // [RULE_14]
        else $error("idle gap between continuous conversions");

    property p_avg_count;
        @(posedge clk_i) disable iff (sys_rst_i)
        (result_valid_o && $past(cont_i) && $past(enable_i))
            |-> (8'($past(done_cnt) + 8'h01) == $past(target));
    endproperty
    a_avg_count: assert property (p_avg_count) // [RULE_12]
        else $error("result published before programmed conversion count");
endmodule

// ===== logic/alsrd_top.sv
// Summary of operation
// RULE_01 - standby when nothing requested, only bus alive
// RULE_02 - emitter sink off in standby, setting kept
// RULE_03 - host writes pointer byte before reading
// RULE_04 - next read returns pointed register contents
// RULE_05 - stop or repeated start both accepted
// RULE_06 - pointer advances after every byte read
// RULE_07 - answer write address 26h, read 27h
// RULE_08 - result high at 85, low at 86
// RULE_09 - config bit 7 selects continuous conversion
// RULE_10 - standard mode uses fixed 100 ms frame
// RULE_11 - single conversion takes about 300 us
// RULE_12 - average programmed count of conversions, up to 128
// RULE_13 - standard result only at frame end
// RULE_14 - continuous conversions run back to back
// RULE_15 - result bytes update together as pair
// RULE_16 - acknowledge address and pointer, release host slots
`timescale 1ns/10ps
module alsrd_top #(
    parameter int FRAME_CYCLES = alsrd_pkg::FRAME_CYCLES,
    parameter int CONV_CYCLES = alsrd_pkg::CONV_CYCLES
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic link_clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic [15:0] adc_data_i,
    output logic conv_busy_o,
    output logic standby_o,
    output logic [7:0] led_sink_o
);
    typedef enum logic [2:0] {L_IDLE, L_ADDR, L_ACK, L_WBYTE, L_RBYTE, L_RACK}
        alsrd_link_state_type;

    // link domain reset and pin synchronisers
    logic lrst_m;
    logic lrst;
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;

    always_ff @(posedge link_clk_i)
    begin
        lrst_m <= sys_rst_i;
        lrst <= lrst_m;
        scl_m <= scl_i;
        scl_s <= scl_m;
        scl_d <= scl_s;
        sda_m <= sda_i;
        sda_s <= sda_m;
        sda_d <= sda_s;
    end

    wire scl_rise = scl_s && !scl_d;
    wire scl_fall = !scl_s && scl_d;
    wire start_det = scl_s && scl_d && sda_d && !sda_s;
    wire stop_det = scl_s && scl_d && !sda_d && sda_s;

    // link engine state
    alsrd_link_state_type state;
    alsrd_link_state_type next_state;
    logic [7:0] shift;
    logic [7:0] next_shift;
    logic [2:0] bit_cnt;
    logic [2:0] next_bit_cnt;
    logic byte_done;
    logic next_byte_done;
    logic is_read;
    logic next_is_read;
    logic got_ptr;
    logic next_got_ptr;
    logic [7:0] ptr;
    logic [7:0] next_ptr;
    logic [7:0] tx;
    logic [7:0] next_tx;
    logic drive_low;
    logic next_drive_low;
    logic host_ack;
    logic next_host_ack;
    logic wr_en;
    logic load_tx;
    logic wr_q;

    // link side registers
    logic [7:0] cmd_reg;
    logic [7:0] led_reg;
    logic [7:0] cfg_reg;
    logic [15:0] res_word;
    logic [7:0] lo_shadow;
    logic shadow_ok;

    wire hit_cmd = (ptr == alsrd_pkg::PTR_CMD);
    wire hit_led = (ptr == alsrd_pkg::PTR_LED);
    wire hit_cfg = (ptr == alsrd_pkg::PTR_CFG);
    wire hit_hi = (ptr == alsrd_pkg::PTR_RES_HI);
    wire hit_lo = (ptr == alsrd_pkg::PTR_RES_LO);
    wire [7:0] lo_byte = shadow_ok ? lo_shadow : res_word[7:0]; // [RULE_15]
    wire [7:0] rd_byte = hit_cmd ? cmd_reg :
                         hit_led ? led_reg :
                         hit_cfg ? cfg_reg :
                         hit_hi ? res_word[15:8] :
                         hit_lo ? lo_byte : alsrd_pkg::READ_NONE; // [RULE_08]
    wire addr_match = (shift[7:1] == alsrd_pkg::DEV_ADDR);

    always_comb
    begin
        next_state = state;
        next_shift = shift;
        next_bit_cnt = bit_cnt;
        next_byte_done = byte_done;
        next_is_read = is_read;
        next_got_ptr = got_ptr;
        next_ptr = ptr;
        next_tx = tx;
        next_drive_low = drive_low;
        next_host_ack = host_ack;
        wr_en = 1'b0;
        load_tx = 1'b0;
        if (stop_det)
        begin
            next_state = L_IDLE;
            next_drive_low = 1'b0;
        end
        else if (start_det)
        begin
            // repeated start keeps the pointer
            next_state = L_ADDR; // [RULE_05]
            next_bit_cnt = 3'h0;
            next_byte_done = 1'b0;
            next_drive_low = 1'b0;
            next_got_ptr = 1'b0;
        end
        else
        begin
            case (state)
                L_ADDR, L_WBYTE:
                begin
                    if (scl_rise)
                    begin
                        next_shift = {shift[6:0], sda_s};
                        next_bit_cnt = bit_cnt + 3'h1;
                        next_byte_done = (bit_cnt == 3'h7);
                    end
                    else if (scl_fall && byte_done)
                    begin
                        next_byte_done = 1'b0;
                        if (state == L_ADDR)
                        begin
                            if (addr_match) // [RULE_07]
                            begin
                                next_state = L_ACK;
                                next_drive_low = 1'b1; // [RULE_16]
                                next_is_read = shift[0];
                            end
                            else
                                next_state = L_IDLE;
                        end
                        else
                        begin
                            next_state = L_ACK;
                            next_drive_low = 1'b1; // [RULE_16]
                            if (!got_ptr)
                            begin
                                next_got_ptr = 1'b1;
                                next_ptr = shift; // [RULE_03]
                            end
                            else
                            begin
                                wr_en = 1'b1;
                                next_ptr = ptr + 8'h01;
                            end
                        end
                    end
                end
                L_ACK:
                begin
                    if (scl_fall)
                    begin
                        next_bit_cnt = 3'h0;
                        if (is_read)
                        begin
                            next_state = L_RBYTE;
                            load_tx = 1'b1;
                            next_tx = rd_byte; // [RULE_04]
                            next_drive_low = !rd_byte[7];
                        end
                        else
                        begin
                            next_state = L_WBYTE;
                            next_drive_low = 1'b0;
                        end
                    end
                end
                L_RBYTE:
                begin
                    if (scl_fall)
                    begin
                        next_bit_cnt = bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7)
                        begin
                            next_state = L_RACK;
                            next_drive_low = 1'b0; // [RULE_16]
                            next_ptr = ptr + 8'h01; // [RULE_06]
                        end
                        else
                        begin
                            next_tx = {tx[6:0], 1'b0};
                            next_drive_low = !tx[6];
                        end
                    end
                end
                L_RACK:
                begin
                    if (scl_rise)
                        next_host_ack = !sda_s;
                    else if (scl_fall)
                    begin
                        if (host_ack)
                        begin
                            next_state = L_RBYTE;
                            next_bit_cnt = 3'h0;
                            load_tx = 1'b1;
                            next_tx = rd_byte; // [RULE_04]
                            next_drive_low = !rd_byte[7];
                        end
                        else
                            next_state = L_IDLE;
                    end
                end
                default:
                    next_state = L_IDLE;
            endcase
        end
    end

    always_ff @(posedge link_clk_i)
    begin
        if (lrst)
        begin
            state <= L_IDLE;
            shift <= 8'h00;
            bit_cnt <= 3'h0;
            byte_done <= 1'b0;
            is_read <= 1'b0;
            got_ptr <= 1'b0;
            ptr <= 8'h00;
            tx <= 8'h00;
            drive_low <= 1'b0;
            host_ack <= 1'b0;
        end
        else
        begin
            state <= next_state;
            shift <= next_shift;
            bit_cnt <= next_bit_cnt;
            byte_done <= next_byte_done;
            is_read <= next_is_read;
            got_ptr <= next_got_ptr;
            ptr <= next_ptr;
            tx <= next_tx;
            drive_low <= next_drive_low;
            host_ack <= next_host_ack;
        end
    end

    // writable registers, low byte snapshot on high byte read
    always_ff @(posedge link_clk_i)
    begin
        if (lrst)
        begin
            cmd_reg <= alsrd_pkg::CMD_RESET;
            led_reg <= alsrd_pkg::LED_RESET;
            cfg_reg <= alsrd_pkg::CFG_RESET;
            lo_shadow <= 8'h00;
            shadow_ok <= 1'b0;
            wr_q <= 1'b0;
        end
        else
        begin
            wr_q <= wr_en;
            if (wr_en && hit_cmd)
                cmd_reg <= shift;
            if (wr_en && hit_led)
                led_reg <= shift;
            if (wr_en && hit_cfg)
                cfg_reg <= shift;
            if (load_tx)
            begin
                shadow_ok <= hit_hi; // [RULE_15]
                lo_shadow <= res_word[7:0];
            end
        end
    end

    // open drain: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe_n_o = !drive_low;

    // settings to system domain
    logic [alsrd_pkg::XFER_W-1:0] sys_word;
    wire [alsrd_pkg::XFER_W-1:0] link_word = {cmd_reg[alsrd_pkg::CMD_PROX_EN_BIT],
        cmd_reg[alsrd_pkg::CMD_ALS_EN_BIT], led_reg, cfg_reg};

    alsrd_word_xfer #(.WIDTH(alsrd_pkg::XFER_W)) u_cfg_xfer (
        .src_clk_i(link_clk_i),
        .src_rst_i(lrst),
        .send_i(wr_q),
        .data_i(link_word),
        .dst_clk_i(clk_i),
        .dst_rst_i(sys_rst_i),
        .data_o(sys_word),
        .valid_o()
    );

    wire sys_prox_en = sys_word[alsrd_pkg::XFER_PROX_BIT];
    wire sys_als_en = sys_word[alsrd_pkg::XFER_ALS_BIT];
    wire [7:0] sys_led = sys_word[alsrd_pkg::XFER_LED_LSB +: 8];
    wire [7:0] sys_cfg = sys_word[alsrd_pkg::XFER_CFG_LSB +: 8];

    assign standby_o = !(sys_prox_en || sys_als_en); // [RULE_01]
    assign led_sink_o = sys_prox_en ? sys_led : 8'h00; // [RULE_02]

    logic [15:0] result;
    logic result_valid;

    alsrd_conv #(.FRAME_CYCLES(FRAME_CYCLES), .CONV_CYCLES(CONV_CYCLES)) u_conv (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .enable_i(sys_als_en),
        .cont_i(sys_cfg[alsrd_pkg::CFG_CONT_BIT]), // [RULE_09]
        .avg_sel_i(sys_cfg[alsrd_pkg::CFG_AVG_LSB +: alsrd_pkg::CFG_AVG_W]),
        .adc_data_i(adc_data_i),
        .conv_busy_o(conv_busy_o),
        .result_o(result),
        .result_valid_o(result_valid)
    );

    // both result bytes cross as one word
    alsrd_word_xfer #(.WIDTH(16)) u_res_xfer (
        .src_clk_i(clk_i),
        .src_rst_i(sys_rst_i),
        .send_i(result_valid),
        .data_i(result),
        .dst_clk_i(link_clk_i),
        .dst_rst_i(lrst),
        .data_o(res_word), // [RULE_15]
        .valid_o()
    );

    property p_addr_ack;
        @(posedge link_clk_i) disable iff (lrst)
        (state == L_ADDR && scl_fall && byte_done && !start_det && !stop_det)
            |=> (sda_oe_n_o == ($past(shift[7:1]) != alsrd_pkg::DEV_ADDR));
    endproperty
    a_addr_ack: assert property (p_addr_ack) // [RULE_07]
        else $error("address acknowledge wrong");

    property p_release_rack;
        @(posedge link_clk_i) disable iff (lrst)
        (state == L_RACK) |-> sda_oe_n_o;
    endproperty
    a_release_rack: assert property (p_release_rack) // [RULE_16]
        else $error("data line held in host acknowledge slot");

    property p_ptr_inc;
        @(posedge link_clk_i) disable iff (lrst)
        (state == L_RBYTE && scl_fall && bit_cnt == 3'h7 && !start_det && !stop_det)
            |=> (ptr == 8'($past(ptr) + 8'h01)) && (state == L_RACK);
    endproperty
    a_ptr_inc: assert property (p_ptr_inc) // [RULE_06]
        else $error("pointer not advanced after read byte");

    property p_load;
        @(posedge link_clk_i) disable iff (lrst)
        (load_tx && !start_det && !stop_det)
            |=> (tx == $past(rd_byte)) && (state == L_RBYTE) && (sda_oe_n_o == tx[7]);
    endproperty
    a_load: assert property (p_load) // [RULE_04]
        else $error("read byte not from pointed register");

    property p_ptr_set;
        @(posedge link_clk_i) disable iff (lrst)
        (state == L_WBYTE && !got_ptr && scl_fall && byte_done && !start_det && !stop_det)
            |=> (ptr == $past(shift)) && got_ptr && drive_low && (state == L_ACK);
    endproperty
    a_ptr_set: assert property (p_ptr_set) // [RULE_03]
        else $error("pointer byte not taken");

    property p_rstart_keeps_ptr;
        @(posedge link_clk_i) disable iff (lrst)
        start_det |=> (ptr == $past(ptr)) && (state == L_ADDR);
    endproperty
    a_rstart_keeps_ptr: assert property (p_rstart_keeps_ptr) // [RULE_05]
        else $error("start lost the pointer");

    property p_pair;
        @(posedge link_clk_i) disable iff (lrst)
        (load_tx && hit_hi && !start_det && !stop_det)
            |=> shadow_ok && (lo_shadow == $past(res_word[7:0]))
                && (tx == $past(res_word[15:8]));
    endproperty
    a_pair: assert property (p_pair) // [RULE_15]
        else $error("result pair inconsistent");

    property p_standby;
        @(posedge clk_i) disable iff (sys_rst_i)
        standby_o |-> !conv_busy_o && (led_sink_o == 8'h00);
    endproperty
    a_standby: assert property (p_standby) // [RULE_01]
        else $error("activity in standby");

    property p_led_kept;
        @(posedge clk_i) disable iff (sys_rst_i)
        ($past(standby_o) && sys_prox_en && $stable(sys_led)) |-> (led_sink_o == sys_led);
    endproperty
    a_led_kept: assert property (p_led_kept) // [RULE_02]
        else $error("emitter setting lost across standby");
endmodule

// ===== verification/alsrd_host.sv
`timescale 1ns/10ps
module alsrd_host (
    input wire logic link_clk_i,
    input wire logic dev_sda_i,
    input wire logic dev_sda_oe_n_i,
    output logic scl_o,
    output logic sda_o,
    output logic [8:0] rx_o,
    output logic rx_stb_o
);
    logic drv = 1'b1;
    // open-drain line with pull-up
    assign sda_o = drv & (dev_sda_oe_n_i | dev_sda_i);
    initial
    begin
        scl_o = 1'b1;
        rx_o = 9'h000;
        rx_stb_o = 1'b0;
    end
    task automatic half();
        repeat (8) @(posedge link_clk_i);
    endtask
    // data held two cycles past the clock fall
    task automatic bit_io(input logic b, output logic r);
        repeat (2) @(posedge link_clk_i);
        drv <= b;
        half();
        scl_o <= 1'b1;
        half();
        r = sda_o;
        scl_o <= 1'b0;
    endtask
    // start or repeated start
    task automatic start();
        repeat (2) @(posedge link_clk_i);
        drv <= 1'b1;
        half();
        scl_o <= 1'b1;
        half();
        drv <= 1'b0;
        half();
        scl_o <= 1'b0;
    endtask
    task automatic stop();
        repeat (2) @(posedge link_clk_i);
        drv <= 1'b0;
        half();
        scl_o <= 1'b1;
        half();
        drv <= 1'b1;
        half();
    endtask
    // eight bits then the acknowledge slot
    task automatic xfer(input logic [7:0] w, input logic a);
        logic [8:0] s;
        logic [8:0] r;
        s = {w, a};
        for (int i = 8; i >= 0; i--)
            bit_io(s[i], r[i]);
        rx_o <= r;
        rx_stb_o <= 1'b1;
        @(posedge link_clk_i);
        rx_stb_o <= 1'b0;
    endtask
endmodule

// ===== verification/alsrd_top_tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
    $display("mismatch at %0t: got %h expected %h", $time, a, e); end end
module alsrd_top_tb;
    localparam int FRAME = 4000;
    localparam int CONV = 20;
    logic clk_i = 1'b0;
    logic link_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [15:0] adc_data_i = 16'h0000;
    logic scl, sda, sda_o, sda_oe_n_o, conv_busy_o, standby_o, rx_stb;
    logic [7:0] led_sink_o, led;
    logic [8:0] rx;
    logic [8:0] exp_q[$];
    logic [8:0] exp_rx;
    int mismatches = 0;
    int checks_done = 0;
    int busy_cnt = 0;
    int b0;
    always #20 clk_i = ~clk_i;
    initial
    begin
        #7;
        forever #32 link_clk_i = ~link_clk_i;
    end
    alsrd_top #(.FRAME_CYCLES(FRAME), .CONV_CYCLES(CONV)) uut (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .link_clk_i(link_clk_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .adc_data_i(adc_data_i),
        .conv_busy_o(conv_busy_o), .standby_o(standby_o), .led_sink_o(led_sink_o));
    alsrd_host host (.link_clk_i(link_clk_i), .dev_sda_i(sda_o), .dev_sda_oe_n_i(sda_oe_n_o),
        .scl_o(scl), .sda_o(sda), .rx_o(rx), .rx_stb_o(rx_stb));
    always @(posedge clk_i)
        busy_cnt <= busy_cnt + int'(conv_busy_o);
    always @(posedge link_clk_i)
        if (rx_stb)
        begin
            exp_rx = exp_q.pop_front();
            `CHK(rx, exp_rx)
        end
    task automatic bx(input logic [7:0] w, input logic a, input logic [8:0] e);
        exp_q.push_back(e);
        host.xfer(w, a);
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        host.start();
        bx(8'h26, 1'b1, {8'h26, 1'b0});
        bx(p, 1'b1, {p, 1'b0});
        bx(d, 1'b1, {d, 1'b0});
        host.stop();
        repeat (30) @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] p, input logic sr, input int n, input logic [31:0] d);
        logic l;
        host.start();
        bx(8'h26, 1'b1, {8'h26, 1'b0});
        bx(p, 1'b1, {p, 1'b0});
        if (!sr)
            host.stop();
        host.start();
        bx(8'h27, 1'b1, {8'h27, 1'b0});
        for (int i = 0; i < n; i++)
        begin
            l = (i == n - 1);
            bx(8'hFF, l, {d[31-8*i -: 8], l});
        end
        host.stop();
    endtask
    task automatic window(input int e);
        b0 = busy_cnt;
        repeat (FRAME) @(posedge clk_i);
        `CHK(busy_cnt - b0, e)
    endtask
    task automatic test_done();
        if (mismatches == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge clk_i);
        mismatches++;
        test_done();
    end
    initial
    begin
        void'($urandom(54));
        led = 8'($urandom);
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        adc_data_i <= 16'($urandom);
        repeat (4) @(posedge link_clk_i);
        `CHK({standby_o, led_sink_o, conv_busy_o}, {1'b1, 8'h00, 1'b0})
        wr(alsrd_pkg::PTR_LED, led);
        wr(alsrd_pkg::PTR_CMD, 8'h02);
        `CHK({standby_o, led_sink_o}, {1'b0, led})
        wr(alsrd_pkg::PTR_CMD, 8'h00);
        `CHK({standby_o, led_sink_o}, {1'b1, 8'h00})
        host.start();
        bx(8'h28, 1'b1, {8'h28, 1'b1});
        host.stop();
        wr(alsrd_pkg::PTR_CFG, 8'h01);
        wr(alsrd_pkg::PTR_CMD, 8'h04);
        `CHK(standby_o, 1'b0)
        rd(alsrd_pkg::PTR_RES_HI, 1'b0, 2, 32'h0);
        window(2 * CONV);
        rd(alsrd_pkg::PTR_LED, 1'b1, 4, {led, 8'h01, adc_data_i});
        @(posedge clk_i);
        adc_data_i <= 16'($urandom);
        wr(alsrd_pkg::PTR_CFG, 8'h83);
        repeat (300) @(posedge clk_i);
        window(FRAME);
        rd(alsrd_pkg::PTR_RES_HI, 1'b0, 2, {adc_data_i, 16'h0});
        `CHK(exp_q.size(), 0)
        test_done();
    end
endmodule
